// ---- pcs_coding.sv ----
/*
  100 Mb/s coding path: MII nibbles to MLT-3 streams and back, plus the
  10BASE-T configuration/status register on an Avalon-MM slave.
  assumes line inputs and the recovered bit clock arrive unsynchronised.
*/
`timescale 1ns/1ps
module pcs_coding #(
  parameter int LOCK_N = pcs_pkg::LOCK_BITS
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire pcs_pkg::av_req_t av,
  output logic [31:0] av_readdata,
  output logic av_waitrequest,
  input wire pcs_pkg::mii_tx_t tx_mii,
  output logic tx_take,
  output logic mlt_pos,
  output logic mlt_neg,
  input wire logic rx_line_pos,
  input wire logic rx_line_neg,
  input wire logic rx_bit_clk,
  input wire logic pol_rev_in,
  output pcs_pkg::mii_rx_t rx_mii,
  output logic rx_strobe,
  output logic link_pulse_enable,
  output logic force_good_link,
  output logic heartbeat_on,
  output logic squelch_low,
  output logic jabber_on
);
  import pcs_pkg::*;

  if (LOCK_N < 1 || LOCK_N > 63) begin : g_chk
    $error("LOCK_N out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // register slave
  logic ack_r;
  logic [15:0] ctrl_r;
  logic [15:0] tenbt_r;
  logic pol_flag_r;
  logic in_frame_r;
  logic lock_r;
  logic [31:0] rdata_r;
  logic [5:0] idx;
  logic req;
  logic bp_code;
  logic bp_scr;

  assign idx = av.address[7:2];
  assign req = av.read | av.write;
  assign av_waitrequest = req & ~ack_r;
  assign av_readdata = rdata_r;
  assign bp_code = ctrl_r[C_BP_CODE];
  assign bp_scr = ctrl_r[C_BP_SCR];

  always_ff @(posedge clk_sys) begin
    if (reset) ack_r <= 1'b0;
    else ack_r <= req & ~ack_r;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata_r <= 32'h0000_0000;
    end else if (av.read & ~ack_r) begin
      unique case (idx)
        IDX_CTRL: rdata_r <= {16'h0000, ctrl_r};
        IDX_STAT: rdata_r <= {30'h0000_0000, in_frame_r, lock_r};
        IDX_TENBT: rdata_r <= {16'h0000, tenbt_r | {15'h0000, pol_flag_r}}; // R5 R6
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tenbt_r <= TENBT_RST; // R1 R2 R3 R4
      ctrl_r <= CTRL_RST;
    end else if (av.write & ack_r) begin
      if (idx == IDX_TENBT) tenbt_r <= av.writedata[15:0] & TENBT_WMASK; // R6
      if (idx == IDX_CTRL) ctrl_r <= av.writedata[15:0] & CTRL_WMASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      link_pulse_enable <= 1'b0;
      force_good_link <= 1'b0;
      heartbeat_on <= 1'b0;
      squelch_low <= 1'b0;
      jabber_on <= 1'b0;
    end else begin
      link_pulse_enable <= tenbt_r[B_LP] & ctrl_r[C_SPD10]; // R1
      force_good_link <= ~tenbt_r[B_LP] & ctrl_r[C_SPD10]; // R1
      heartbeat_on <= tenbt_r[B_HB] & ~ctrl_r[C_FDX]; // R2
      squelch_low <= ~tenbt_r[B_SQ]; // R3
      jabber_on <= tenbt_r[B_JAB] & ctrl_r[C_SPD10] & (ctrl_r[C_FDX] | ctrl_r[C_LOOP]); // R4
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit: encode, scramble, serialize, NRZI, MLT-3
  tx_state_t tx_st_r;
  tx_state_t tx_st_nxt;
  logic [2:0] cnt_r;
  logic [4:0] sh_r;
  logic [4:0] grp_c;
  logic [4:0] grp_last_r;
  logic [10:0] scr_r;
  logic [15:0] scr5;
  logic load;
  logic nrzi_tx_r;
  logic dir_r;

  // five key bits in send order and the advanced state
  function automatic logic [15:0] scr_step(input logic [10:0] s);
    logic [4:0] k;
    logic [10:0] t;
    k = 5'h00;
    t = s;
    for (int i = 4; i >= 0; i--) begin
      k[i] = t[10] ^ t[8];
      t = {t[9:0], k[i]};
    end
    scr_step = {k, t};
  endfunction

  assign load = (cnt_r == GRP_LAST);
  assign scr5 = scr_step(scr_r);

  always_comb begin
    tx_st_nxt = tx_st_r;
    tx_take = 1'b0;
    grp_c = CG_I; // R10
    if (bp_code) begin
      tx_st_nxt = TX_IDLE;
      tx_take = load & tx_mii.en;
      if (tx_mii.en) grp_c = {tx_mii.er, tx_mii.d}; // R11
    end else begin
      unique case (tx_st_r)
        TX_IDLE: begin
          if (tx_mii.en) begin
            grp_c = CG_J; // R8
            tx_take = load;
            tx_st_nxt = TX_K;
          end
        end
        TX_K: begin
          grp_c = CG_K; // R8
          tx_take = load;
          tx_st_nxt = TX_DATA;
        end
        TX_DATA: begin
          if (tx_mii.en) begin
            grp_c = ENC[tx_mii.d]; // R7
            tx_take = load;
          end else begin
            grp_c = CG_T; // R9
            tx_st_nxt = TX_R;
          end
        end
        TX_R: begin
          grp_c = CG_R; // R9
          tx_st_nxt = TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt_r <= 3'h0;
      tx_st_r <= TX_IDLE;
      sh_r <= CG_I;
      grp_last_r <= CG_I;
      scr_r <= SCR_SEED;
    end else if (load) begin
      cnt_r <= 3'h0;
      tx_st_r <= tx_st_nxt;
      grp_last_r <= grp_c;
      scr_r <= scr5[10:0]; // R24
      sh_r <= bp_scr ? grp_c : grp_c ^ scr5[15:11]; // R12
    end else begin
      cnt_r <= cnt_r + 3'h1;
      sh_r <= {sh_r[3:0], 1'b0}; // R13
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      nrzi_tx_r <= 1'b0;
      mlt_pos <= 1'b0;
      mlt_neg <= 1'b0;
      dir_r <= 1'b0;
    end else begin
      nrzi_tx_r <= nrzi_tx_r ^ sh_r[4]; // R14
      if (sh_r[4]) begin // R15
        if (mlt_pos | mlt_neg) begin
          mlt_pos <= 1'b0;
          mlt_neg <= 1'b0;
        end else begin
          mlt_pos <= ~dir_r;
          mlt_neg <= dir_r;
          dir_r <= ~dir_r;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive front: {pol, bit clock, neg, pos} through three flops
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic [3:0] s3_r;
  logic [3:0] st_r;
  logic stb;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s1_r <= 4'h0;
      s2_r <= 4'h0;
      s3_r <= 4'h0;
      st_r <= 4'h0;
    end else begin
      s1_r <= {pol_rev_in, rx_bit_clk, rx_line_neg, rx_line_pos};
      s2_r <= s1_r;
      s3_r <= s2_r;
      st_r <= (s3_r & ~(s2_r ^ s3_r)) | (st_r & (s2_r ^ s3_r));
    end
  end

  assign stb = s2_r[2] & s3_r[2] & ~st_r[2]; // R18

  always_ff @(posedge clk_sys) begin
    if (reset) pol_flag_r <= 1'b0;
    else pol_flag_r <= st_r[3]; // R5
  end

  ////////////////////////////////////////////////////////////////////////
  // receive: MLT-3, NRZI, descramble, align, decode
  logic [1:0] lvl_r;
  logic nrzi_rx_r;
  logic nrzi_nxt;
  logic nrz;
  logic [10:0] ds_r;
  logic dkey;
  logic plain;
  logic [5:0] lock_cnt_r;
  logic [8:0] win_r;
  logic [9:0] win_c;
  logic [2:0] ph_r;
  logic pre2_r;
  logic [4:0] dec;

  assign nrzi_nxt = nrzi_rx_r ^ (st_r[1:0] != lvl_r); // R17
  assign nrz = nrzi_nxt ^ nrzi_rx_r; // R19
  assign dkey = ds_r[10] ^ ds_r[8];
  assign plain = bp_scr ? nrz : (lock_r ? nrz ^ dkey : 1'b1); // R20
  assign win_c = {win_r, plain};
  assign dec = dec5(win_c[4:0]);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lvl_r <= 2'h0;
      nrzi_rx_r <= 1'b0;
    end else if (stb) begin
      lvl_r <= st_r[1:0];
      nrzi_rx_r <= nrzi_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ds_r <= 11'h000;
      lock_r <= 1'b0;
      lock_cnt_r <= 6'h00;
    end else if (stb) begin
      if (lock_r) begin
        ds_r <= {ds_r[9:0], dkey};
      end else begin
        ds_r <= {ds_r[9:0], ~nrz}; // R24
        if (~nrz != dkey) lock_cnt_r <= 6'h00;
        else if (lock_cnt_r == 6'(LOCK_N - 1)) lock_r <= 1'b1;
        else lock_cnt_r <= lock_cnt_r + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      win_r <= 9'h1FF;
      ph_r <= 3'h0;
      in_frame_r <= 1'b0;
      pre2_r <= 1'b0;
      rx_mii <= '0;
      rx_strobe <= 1'b0;
    end else begin
      rx_strobe <= 1'b0;
      if (stb) begin
        win_r <= win_c[8:0];
        ph_r <= (ph_r == GRP_LAST) ? 3'h0 : ph_r + 3'h1;
        pre2_r <= 1'b0;
        if (pre2_r) begin
          rx_strobe <= 1'b1; // R22
        end
        if (bp_code) begin
          if (ph_r == GRP_LAST) begin
            rx_mii <= '{dv: 1'b1, er: win_c[4], d: win_c[3:0]}; // R11
            rx_strobe <= 1'b1;
          end
        end else if (~in_frame_r) begin
          if (win_c == {CG_J, CG_K}) begin // R21
            in_frame_r <= 1'b1;
            ph_r <= 3'h0;
            pre2_r <= 1'b1;
            rx_mii <= '{dv: 1'b1, er: 1'b0, d: NIB_PRE}; // R22
            rx_strobe <= 1'b1;
          end
        end else if (ph_r == GRP_LAST) begin // R16
          if (win_c[4:0] == CG_T || win_c[4:0] == CG_I) begin
            in_frame_r <= 1'b0; // R23
            rx_mii <= '0;
          end else begin
            rx_mii <= '{dv: 1'b1, er: ~dec[4], d: dec[3:0]}; // R25
            rx_strobe <= 1'b1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  AST_LP: assert property (@(posedge clk_sys) disable iff (reset) // R1
    ctrl_r[C_SPD10] && !tenbt_r[B_LP] |-> ##1 force_good_link && !link_pulse_enable)
    else $error("link pulse bit not forcing good link");

  AST_HB: assert property (@(posedge clk_sys) disable iff (reset) // R2
    ctrl_r[C_FDX] ##1 ctrl_r[C_FDX] |-> !heartbeat_on)
    else $error("heartbeat active in full duplex");

  AST_RESV: assert property (@(posedge clk_sys) disable iff (reset) // R6
    av.read && !ack_r && idx == IDX_TENBT |=> rdata_r[31:15] == 17'h00000
      && rdata_r[10:1] == 10'h000)
    else $error("reserved bits read non-zero");

  AST_TX_JK: assert property (@(posedge clk_sys) disable iff (reset) // R8
    load && !bp_code && tx_st_r == TX_IDLE && tx_mii.en
      |=> grp_last_r == CG_J ##5 grp_last_r == CG_K)
    else $error("start delimiter wrong");

  AST_TX_TR: assert property (@(posedge clk_sys) disable iff (reset) // R9
    load && !bp_code && tx_st_r == TX_DATA && !tx_mii.en
      |=> grp_last_r == CG_T ##5 grp_last_r == CG_R)
    else $error("end delimiter wrong");

  AST_TX_IDLE: assert property (@(posedge clk_sys) disable iff (reset) // R10
    load && !bp_code && tx_st_r == TX_R ##5 !tx_mii.en |=> grp_last_r == CG_I)
    else $error("idle not sent after end delimiter");

  AST_SCR: assert property (@(posedge clk_sys) disable iff (reset) // R12
    load && !bp_scr |=> sh_r == (grp_last_r ^ $past(scr5[15:11])))
    else $error("scrambled group mismatch");

  AST_MLT: assert property (@(posedge clk_sys) disable iff (reset) // R15
    !(mlt_pos && mlt_neg) and ($changed(nrzi_tx_r) |-> $changed({mlt_pos, mlt_neg})))
    else $error("mlt-3 streams wrong");

  AST_PRE: assert property (@(posedge clk_sys) disable iff (reset) // R22
    ($rose(in_frame_r) && !bp_code |-> rx_strobe && rx_mii.d == NIB_PRE && pre2_r)
      and (pre2_r && stb |=> rx_strobe && rx_mii.dv && rx_mii.d == NIB_PRE))
    else $error("preamble nibbles missing");
endmodule

// ---- pcs_pkg.sv ----
/*
  constants, carriers and code tables of the 100 Mb/s coding path and its registers.
  assumes a 125 MHz system clock carrying one line bit per cycle on transmit.
*/
// Contract
// [R1] link pulse bit: reset one, zero forces link
// [R2] heartbeat bit: reset one, ignored in full duplex
// [R3] squelch bit: reset one normal, zero low
// [R4] jabber bit: reset one, acts 10M fdx/loopback
// [R5] polarity flag: read only, follows 10M receiver
// [R6] reserved bits read zero, written zero
// [R7] nibbles map to 5-bit groups by table
// [R8] frame starts with J then K groups
// [R9] transmit enable low appends T then R
// [R10] idle groups fill between frames
// [R11] option bypasses the 4B5B conversion
// [R12] scrambler key XORs the 5-bit group
// [R13] serializer shifts groups out bitwise
// [R14] serial stream is NRZI encoded
// [R15] MLT-3 splits into alternating two streams
// [R16] receive turns line bits into nibbles
// [R17] MLT-3 levels decode into NRZI
// [R18] recovered bit clock strobes line data
// [R19] NRZI decodes back to NRZ
// [R20] descrambler undoes scrambling before alignment
// [R21] alignment starts at J/K, fixed boundary
// [R22] J/K replaced by two preamble nibbles
// [R23] T/R never reaches the MII
// [R24] eleven-stage scrambler, descrambler locks on idle
// [R25] invalid or H group in frame flags error
package pcs_pkg;
  localparam logic [5:0] IDX_CTRL = 6'h10;
  localparam logic [5:0] IDX_STAT = 6'h11;
  localparam logic [5:0] IDX_TENBT = 6'h12;
  localparam int B_LP = 14;
  localparam int B_HB = 13;
  localparam int B_SQ = 12;
  localparam int B_JAB = 11;
  localparam logic [15:0] TENBT_RST = 16'h7800;
  localparam logic [15:0] TENBT_WMASK = 16'h7800;
  localparam int C_BP_CODE = 0;
  localparam int C_BP_SCR = 1;
  localparam int C_SPD10 = 2;
  localparam int C_FDX = 3;
  localparam int C_LOOP = 4;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'h001F;
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0D;
  localparam logic [4:0] CG_R = 5'h07;
  localparam logic [4:0] CG_I = 5'h1F;
  localparam logic [3:0] NIB_PRE = 4'h5;
  localparam logic [2:0] GRP_LAST = 3'h4;
  localparam logic [10:0] SCR_SEED = 11'h7FF;
  localparam int LOCK_BITS = 30;
  localparam logic [4:0] ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
    5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  typedef struct packed {logic en; logic er; logic [3:0] d;} mii_tx_t;
  typedef struct packed {logic dv; logic er; logic [3:0] d;} mii_rx_t;
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } av_req_t;
  typedef enum {TX_IDLE, TX_K, TX_DATA, TX_R} tx_state_t;

  // {valid, nibble}; valid low for control, error and invalid groups
  function automatic logic [4:0] dec5(input logic [4:0] g);
    dec5 = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (ENC[i] == g) dec5 = {1'b1, 4'(i)};
    end
  endfunction
endpackage

// ---- mac_model.sv ----
/*
  mac-side partner: hands transmit nibbles over on demand, collects receive nibbles.
  assumes tx_take and rx_strobe are sampled at rising clk_sys edges.
*/
`timescale 1ns/1ps
module mac_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic tx_take,
  input wire pcs_pkg::mii_rx_t rx_mii,
  input wire logic rx_strobe,
  output pcs_pkg::mii_tx_t tx_mii
);
  import pcs_pkg::*;
  logic [4:0] tx_q[$];
  logic [4:0] rx_q[$];
  ////////////////////////////////////////
  // nibble held until taken; released data line shows its inverse
  always @(posedge clk_sys) begin
    if (reset) begin
      tx_mii <= '0;
    end else if (tx_mii.en && tx_take) begin
      void'(tx_q.pop_front());
      if (tx_q.size() != 0) begin
        {tx_mii.er, tx_mii.d} <= tx_q[0];
      end else begin
        tx_mii.en <= 1'b0;
        tx_mii.er <= 1'b0;
        tx_mii.d <= ~tx_mii.d;
      end
    end else if (!tx_mii.en && tx_q.size() != 0) begin
      tx_mii.en <= 1'b1;
      {tx_mii.er, tx_mii.d} <= tx_q[0];
    end
  end
  ////////////////////////////////////////
  always @(posedge clk_sys) begin
    if (!reset && rx_strobe && rx_mii.dv) begin
      rx_q.push_back({rx_mii.er, rx_mii.d});
    end
  end
endmodule

// ---- pcs_coding_tb_top.sv ----
/*
  bench for the coding path: register bus, transmit line decode, receive line stimulus.
  assumes pcs_pkg, mac_model and a 125 MHz clk_sys.
*/
`timescale 1ns/1ps
module pcs_coding_tb_top;
  import pcs_pkg::*;
  localparam logic [4:0] TAB [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
    5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  localparam logic [7:0] CC [5] = '{8'h04, 8'h0C, 8'h0C, 8'h14, 8'h00};
  localparam logic [15:0] CT [5] = '{16'h7800, 16'h7800, 16'h0000, 16'h6800, 16'h7800};
  localparam logic [4:0] CE [5] = '{5'h14, 5'h11, 5'h0A, 5'h17, 5'h04};
  localparam logic [4:0] CM [5] = '{5'h1E, 5'h1F, 5'h1F, 5'h1F, 5'h1F};
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  av_req_t av = '0;
  logic [31:0] av_readdata;
  logic av_waitrequest, tx_take, mlt_pos, mlt_neg, rx_strobe;
  logic rx_line_pos = 1'b0, rx_line_neg = 1'b0, rx_bit_clk = 1'b0, pol_rev_in = 1'b0;
  mii_tx_t tx_mii;
  mii_rx_t rx_mii;
  logic [4:0] cfg, grp, got_g[$];
  logic [1:0] cur, lvl_p = 2'b00, last_nz = 2'b00, mst = 2'b00;
  logic [10:0] kh = '0, rk = 11'h5A5;
  logic [9:0] win = '0;
  logic sb, k, pb, framed = 1'b0;
  int fail_count = 0, n_tests = 0, cyc = 0, nbit = 0, gcnt = 0;
  always #4 clk_sys = ~clk_sys;
  pcs_coding #(.LOCK_N(8)) DUT (.clk_sys(clk_sys), .reset(reset), .av(av),
    .av_readdata(av_readdata), .av_waitrequest(av_waitrequest), .tx_mii(tx_mii),
    .tx_take(tx_take), .mlt_pos(mlt_pos), .mlt_neg(mlt_neg), .rx_line_pos(rx_line_pos),
    .rx_line_neg(rx_line_neg), .rx_bit_clk(rx_bit_clk), .pol_rev_in(pol_rev_in),
    .rx_mii(rx_mii), .rx_strobe(rx_strobe), .link_pulse_enable(cfg[4]),
    .force_good_link(cfg[3]), .heartbeat_on(cfg[2]), .squelch_low(cfg[1]),
    .jabber_on(cfg[0]));
  mac_model mac (.clk_sys(clk_sys), .reset(reset), .tx_take(tx_take), .rx_mii(rx_mii),
    .rx_strobe(rx_strobe), .tx_mii(tx_mii));
  ////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] wd,
      output logic [31:0] rd);
    av <= '{address: {a[7:2], 2'($urandom)}, read: !wr, write: wr,
      writedata: {16'($urandom), wd}};
    do begin
      @(posedge clk_sys);
    end while (av_waitrequest !== 1'b0);
    rd = av_readdata;
    av <= '0;
    @(posedge clk_sys);
  endtask
  ////////////////////////////////////////
  // line monitor: level change is a one, idle before a frame keys the descrambler
  always @(posedge clk_sys) begin
    cur = {mlt_pos, mlt_neg};
    if (!reset) begin
      if (lvl_p == 2'b00 && cur != 2'b00 && last_nz != 2'b00) begin
        check(cur ^ last_nz, 2'b11);
      end
      if (cur != 2'b00) last_nz = cur;
      sb = (cur != lvl_p);
      k = (nbit < 40) ? !sb : kh[10] ^ kh[8];
      kh = {kh[9:0], k};
      pb = sb ^ k;
      nbit++;
      if (!framed) begin
        win = {win[8:0], pb};
        framed = (win == 10'h311);
        gcnt = 0;
      end else begin
        grp = {grp[3:0], pb};
        gcnt++;
        if (gcnt == 5) begin
          got_g.push_back(grp);
          gcnt = 0;
          framed = (grp != 5'h1F);
        end
      end
    end
    lvl_p = cur;
  end
  // raw: coding bypassed, the mac hands {er, d} groups including J/K and T/R
  task automatic tx_frame(input int n, input logic raw);
    logic [4:0] e[$];
    logic [4:0] v;
    nbit = 0;
    framed = 1'b0;
    repeat (60) @(posedge clk_sys);
    got_g.delete();
    mac.tx_q.push_back(raw ? 5'h18 : 5'h05);
    mac.tx_q.push_back(raw ? 5'h11 : 5'h05);
    for (int i = 0; i < n; i++) begin
      v = (i == 0) ? 5'h00 : (i == 1) ? 5'h0F : 5'($urandom);
      if (!raw) v[4] = 1'b0;
      else if (v == 5'h1F) v = 5'h1E;
      mac.tx_q.push_back(v);
      e.push_back(raw ? v : TAB[v[3:0]]);
    end
    if (raw) begin
      mac.tx_q.push_back(5'h0D);
      mac.tx_q.push_back(5'h07);
    end
    e.push_back(5'h0D);
    e.push_back(5'h07);
    e.push_back(5'h1F);
    while (got_g.size() < e.size()) @(posedge clk_sys);
    for (int i = 0; i < e.size(); i++) check(got_g[i], e[i]);
  endtask
  ////////////////////////////////////////
  // one line bit per 8 clocks: 64 ns recovered clock, data changes as it falls
  task automatic rx_bit(input logic b);
    k = rk[10] ^ rk[8];
    rk = {rk[9:0], k};
    if (b ^ k) mst = mst + 2'd1;
    rx_bit_clk <= 1'b0;
    rx_line_pos <= (mst == 2'd1);
    rx_line_neg <= (mst == 2'd3);
    repeat (4) @(posedge clk_sys);
    rx_bit_clk <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic rx_test(input logic bad);
    logic [4:0] g[$];
    logic [4:0] e[$];
    logic [3:0] v;
    mac.rx_q.delete();
    repeat (12) g.push_back(5'h1F);
    g.push_back(5'h18);
    g.push_back(5'h11);
    e.push_back(5'h05);
    e.push_back(5'h05);
    for (int i = 0; i < 8; i++) begin
      v = 4'($urandom);
      g.push_back((bad && i == 3) ? 5'h00 : (bad && i == 5) ? 5'h04 : TAB[v]);
      e.push_back((bad && (i == 3 || i == 5)) ? 5'h10 : {1'b0, v});
    end
    g.push_back(5'h0D);
    g.push_back(5'h07);
    repeat (4) g.push_back(5'h1F);
    foreach (g[i]) for (int j = 4; j >= 0; j--) rx_bit(g[i][j]);
    repeat (20) @(posedge clk_sys);
    check(mac.rx_q.size(), e.size());
    check(rx_mii.dv, 1'b0);
    foreach (e[i]) check(mac.rx_q[i], e[i]);
  endtask
  ////////////////////////////////////////
  initial begin
    logic [31:0] x;
    logic [15:0] r;
    x = $urandom(32'h6879D4DE);
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    bus(1'b0, 8'h48, 16'h0000, x);
    check(x, 32'h0000_7800);
    bus(1'b0, 8'hF0, 16'h0000, x);
    check(x, 32'h0);
    bus(1'b0, 8'h3C, 16'h0000, x);
    check(x, 32'h0);
    for (int i = 0; i < 4; i++) begin
      r = (i == 0) ? 16'hFFFF : 16'($urandom);
      bus(1'b1, 8'h48, r, x);
      bus(1'b0, 8'h48, 16'h0000, x);
      check(x, {16'h0000, r & 16'h7800});
    end
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, 8'h40, {8'h00, CC[i]}, x);
      bus(1'b1, 8'h48, CT[i], x);
      repeat (3) @(posedge clk_sys);
      check(cfg & CM[i], CE[i]);
    end
    for (int p = 1; p >= 0; p--) begin
      pol_rev_in <= p[0];
      repeat (6) @(posedge clk_sys);
      bus(1'b0, 8'h48, 16'h0000, x);
      check(x[0], p[0]);
    end
    bus(1'b1, 8'h40, 16'h0000, x);
    tx_frame(8, 1'b0);
    bus(1'b1, 8'h40, 16'h0003, x);
    tx_frame(6, 1'b1);
    bus(1'b1, 8'h40, 16'h0000, x);
    tx_frame(1, 1'b0);
    rx_test(1'b0);
    bus(1'b0, 8'h44, 16'h0000, x);
    check(x, 32'h0000_0001);
    rx_test(1'b1);
    wrap_up();
  end
endmodule
